// [conv_ctrl_pkg.sv]
/*
 * package for the converter control block: register offsets, field
 * positions, reset values, timing counts and shared types.
 * assumes a byte-wide register port reached from the processor side.
 */
`default_nettype none
package conv_ctrl_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CHANNEL_SELECT = 3'h0; // channel_select_register
    localparam logic [2:0] ADDR_CONTROL_A = 3'h1; // converter_control_status_a
    localparam logic [2:0] ADDR_CONTROL_B = 3'h2; // converter_control_status_b
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h3; // result_low_byte
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h4; // result_high_byte
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MUX_LSB = 0; // input_mux_field, 5 bits
    localparam int LEFT_ADJ_BIT = 5; // left_adjust_bit
    localparam int REF_LSB = 6; // reference_select_bits, 2 bits
    localparam int PRESCALE_LSB = 0; // prescaler_select_field, 3 bits
    localparam int DONE_BIT = 4; // conversion_done_flag
    localparam int AUTO_BIT = 5; // auto_trigger_enable_bit
    localparam int START_BIT = 6; // conversion_start_bit
    localparam int ENABLE_BIT = 7; // converter_enable_bit
    localparam int TRIG_LSB = 0; // trigger_source_select, 3 bits
    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int RESULT_WIDTH = 10;
    localparam int TRIG_COUNT = 8;
    localparam logic [2:0] TRIG_SELF_DONE = 3'h0; // done flag as trigger
    // ------------------------------------------------------------
    // conversion timing in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [4:0] NORMAL_CYCLES = 5'h0d; // 13
    localparam logic [4:0] FIRST_CYCLES = 5'h19; // 25
    // selection set applied to the analog path
    typedef struct packed {
        logic [1:0] ref_sel;
        logic [4:0] input_mux_field;
    } analog_sel_t;
endpackage : conv_ctrl_pkg
`default_nettype wire

// [conv_prescaler.sv]
/*
 * converter clock prescaler: one-cycle enable pulse every 2^n system
 * clocks (every 2 for n of 0), held reset while disabled or while a restart is requested.
 * assumes one system clock domain.
 */
`default_nettype none
module conv_prescaler
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_run, // converter enabled
    input wire logic i_restart, // auto-trigger restart
    input wire logic [2:0] i_select, // divide select
    output logic o_tick // converter clock enable
);
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [6:0] count_r;
    logic [6:0] count_nxt;
    logic [6:0] limit;
    logic tick_nxt;

    // divide by 2 for selects 0 and 1, else 2^select
    always_comb
    begin
        limit = (i_select < 3'h2) ? 7'h01 : 7'((8'h01 << i_select) - 8'h01);
        count_nxt = count_r + 7'h01;
        tick_nxt = 1'b0;
        if (!i_run || i_restart)
        begin
            count_nxt = 7'h00;
        end
        else if (count_r >= limit)
        begin
            count_nxt = 7'h00;
            tick_nxt = 1'b1;
        end
    end

    // register stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            count_r <= 7'h00;
            o_tick <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule // conv_prescaler
`default_nettype wire

// [conv_ctrl.sv]
/*
 * converter control: register port, selection buffer, start logic,
 * conversion sequencing, result alignment and read lock.
 * assumes an analog core that accepts a sample strobe and returns a
 * 10-bit code when the conversion ends, and a vector of trigger inputs.
 */
// Local design decisions: the register offsets and strobed register access.
// Overview of operation
// - ten-bit code, zero is ground
// - reference select bits route reference source
// - mux field picks channel, ground, bandgap
// - gain for differential, bypass for single
// - sixteen differential codes, common negative terminal
// - selections reach analog only when enabled
// - right aligned by default, left when set
// - low read locks result until high read
// - done event raised even when discarded
// - start bit launches, stays, clears itself
// - channel change waits for conversion end
// - trigger edge resets prescaler and starts
// - edges during conversion ignored, no relaunch
// - flag sets always, clear before next edge
// - done flag as trigger runs freely
// - start works under auto trigger; reads busy
// - thirteen cycles, first one twenty-five
// - prescaler runs only while enabled
// - completion loads result, sets done flag
// - selection buffer frozen during conversion
`default_nettype none
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int TRIGGERS = conv_ctrl_pkg::TRIG_COUNT
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [2:0] i_addr, // register address
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [7:0] o_rdata, // read data, cycle after strobe
    input wire logic [TRIGGERS-1:0] i_triggers, // internal trigger sources
    input wire logic [9:0] i_code, // code from the analog core
    output conv_ctrl_pkg::analog_sel_t o_sel, // selection to analog path
    output logic o_power, // analog core powered
    output logic o_sample, // start of conversion pulse
    output logic o_done_event // conversion complete event pulse
);
    import conv_ctrl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, PENDING, CONVERT} conv_state_t;
    conv_state_t state_r, state_nxt;
    logic [7:0] chan_r, chan_nxt; // software copy of channel register
    logic [7:0] ctrl_a_r, ctrl_a_nxt; // control a (start/done live)
    logic [2:0] trig_sel_r, trig_sel_nxt; // trigger source select
    analog_sel_t sel_r, sel_nxt; // buffered selection
    logic [9:0] result_r, result_nxt; // stored code
    logic left_r, left_nxt; // alignment at load time
    logic lock_r, lock_nxt; // read lock
    logic first_r, first_nxt; // next conversion is first
    logic [4:0] cyc_r, cyc_nxt; // converter cycles left
    logic trig_prev_r, trig_prev_nxt; // last trigger level
    logic [7:0] rdata_nxt;
    logic sample_nxt, event_nxt, restart;
    logic tick, trig_level, trig_edge, enable, finish;
    logic [15:0] aligned;
    logic first_r_past; // first_r one cycle late, for the length check

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    conv_prescaler u_prescaler
    (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_run(enable),
        .i_restart(restart),
        .i_select(ctrl_a_r[PRESCALE_LSB +: 3]),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // start, sequencing and register logic
    // ------------------------------------------------------------
    always_comb
    begin
        enable = ctrl_a_r[ENABLE_BIT];
        // selected trigger level; select 0 is own done flag
        trig_level = (trig_sel_r == TRIG_SELF_DONE) ? ctrl_a_r[DONE_BIT]
            : i_triggers[trig_sel_r];
        trig_edge = trig_level && !trig_prev_r;
        finish = (state_r == CONVERT) && tick && (cyc_r == 5'h01);
        // result packed into 16 bits, left or right
        aligned = left_r ? {result_r, 6'h00} : {6'h00, result_r};
        state_nxt = state_r;
        chan_nxt = chan_r;
        ctrl_a_nxt = ctrl_a_r;
        trig_sel_nxt = trig_sel_r;
        sel_nxt = sel_r;
        result_nxt = result_r;
        left_nxt = left_r;
        lock_nxt = lock_r;
        first_nxt = first_r;
        cyc_nxt = cyc_r;
        trig_prev_nxt = trig_level;
        rdata_nxt = 8'h00;
        sample_nxt = 1'b0;
        event_nxt = 1'b0;
        restart = 1'b0;
        // register writes
        if (i_wr)
        begin
            case (i_addr)
                ADDR_CHANNEL_SELECT: chan_nxt = i_wdata;
                ADDR_CONTROL_A:
                begin
                    ctrl_a_nxt[ENABLE_BIT] = i_wdata[ENABLE_BIT];
                    ctrl_a_nxt[AUTO_BIT] = i_wdata[AUTO_BIT];
                    ctrl_a_nxt[3:0] = i_wdata[3:0];
                    // start is set-only; done clears on write of one
                    if (i_wdata[START_BIT] && i_wdata[ENABLE_BIT])
                    begin
                        ctrl_a_nxt[START_BIT] = 1'b1;
                    end
                    if (i_wdata[DONE_BIT])
                    begin
                        ctrl_a_nxt[DONE_BIT] = 1'b0;
                    end
                end
                ADDR_CONTROL_B: trig_sel_nxt = i_wdata[TRIG_LSB +: 3];
                default: ;
            endcase
        end
        // register reads, data in the next cycle
        if (i_rd)
        begin
            case (i_addr)
                ADDR_CHANNEL_SELECT: rdata_nxt = chan_r;
                ADDR_CONTROL_A: rdata_nxt = ctrl_a_r;
                ADDR_CONTROL_B: rdata_nxt = {5'h00, trig_sel_r};
                ADDR_RESULT_LOW:
                begin
                    rdata_nxt = aligned[7:0];
                    lock_nxt = 1'b1;
                end
                ADDR_RESULT_HIGH:
                begin
                    rdata_nxt = aligned[15:8];
                    lock_nxt = 1'b0;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
        // buffer tracks register in idle and at the end of a conversion
        if (state_r == IDLE || (state_r == CONVERT && tick
            && cyc_r == 5'h01))
        begin
            sel_nxt = analog_sel_t'({chan_r[REF_LSB +: 2],
                chan_r[MUX_LSB +: 5]});
        end
        // sequencer
        case (state_r)
            IDLE:
            begin
                if (!enable)
                begin
                    first_nxt = 1'b1;
                end
                else if (ctrl_a_r[START_BIT])
                begin
                    state_nxt = PENDING;
                end
                // own done flag never starts from idle: first needs start
                else if (ctrl_a_r[AUTO_BIT] && trig_edge
                    && trig_sel_r != TRIG_SELF_DONE)
                begin
                    restart = 1'b1;
                    ctrl_a_nxt[START_BIT] = 1'b1;
                    state_nxt = PENDING;
                end
            end
            PENDING:
            begin
                // conversion begins on the next converter clock
                if (!enable)
                begin
                    state_nxt = IDLE;
                    ctrl_a_nxt[START_BIT] = 1'b0;
                end
                else if (tick)
                begin
                    state_nxt = CONVERT;
                    sample_nxt = 1'b1;
                    cyc_nxt = first_r ? FIRST_CYCLES : NORMAL_CYCLES;
                    first_nxt = 1'b0;
                end
            end
            CONVERT:
            begin
                // trigger edges here are ignored; prev still tracks
                if (!enable)
                begin
                    state_nxt = IDLE;
                    ctrl_a_nxt[START_BIT] = 1'b0;
                end
                else if (tick)
                begin
                    cyc_nxt = cyc_r - 5'h01;
                    if (cyc_r == 5'h01)
                    begin
                        ctrl_a_nxt[DONE_BIT] = 1'b1;
                        event_nxt = 1'b1;
                        if (!lock_r)
                        begin
                            result_nxt = i_code;
                            left_nxt = chan_r[LEFT_ADJ_BIT];
                        end
                        if (ctrl_a_r[AUTO_BIT]
                            && trig_sel_r == TRIG_SELF_DONE)
                        begin
                            state_nxt = PENDING;
                        end
                        else
                        begin
                            state_nxt = IDLE;
                            ctrl_a_nxt[START_BIT] = 1'b0;
                        end
                    end
                end
            end
            default: state_nxt = IDLE;
        endcase
        // level remains high at finish: no fresh edge afterwards
        if (finish)
        begin
            trig_prev_nxt = 1'b1;
        end
        // disabled and staying so: no start survives; a start written
        // together with the enable bit is kept
        if (!enable && !ctrl_a_nxt[ENABLE_BIT])
        begin
            ctrl_a_nxt[START_BIT] = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= IDLE;
            chan_r <= RESET_BYTE;
            ctrl_a_r <= RESET_BYTE;
            trig_sel_r <= 3'h0;
            sel_r <= '0;
            result_r <= 10'h000;
            left_r <= 1'b0;
            lock_r <= 1'b0;
            first_r <= 1'b1;
            cyc_r <= 5'h00;
            trig_prev_r <= 1'b0;
            o_rdata <= 8'h00;
            o_sel <= '0;
            o_power <= 1'b0;
            o_sample <= 1'b0;
            o_done_event <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
            ctrl_a_r <= ctrl_a_nxt;
            trig_sel_r <= trig_sel_nxt;
            sel_r <= sel_nxt;
            result_r <= result_nxt;
            left_r <= left_nxt;
            lock_r <= lock_nxt;
            first_r <= first_nxt;
            cyc_r <= cyc_nxt;
            trig_prev_r <= trig_prev_nxt;
            o_rdata <= rdata_nxt;
            // analog path sees selection only while enabled
            o_sel <= ctrl_a_nxt[ENABLE_BIT] ? sel_nxt : '0;
            o_power <= ctrl_a_nxt[ENABLE_BIT];
            o_sample <= sample_nxt;
            o_done_event <= event_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_start_clears_done: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (finish && !(ctrl_a_r[AUTO_BIT] && trig_sel_r == TRIG_SELF_DONE))
        |=> (!ctrl_a_r[START_BIT] && ctrl_a_r[DONE_BIT]))
        else $error("start not cleared with done set");
    a_lock_keeps_result: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (lock_r && !i_rd) |=> $stable(result_r))
        else $error("locked result changed");
    a_event_on_finish: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        finish |=> o_done_event)
        else $error("done event missing");
    a_busy_reads_start: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_r == CONVERT) |-> ctrl_a_r[START_BIT])
        else $error("start bit low during conversion");
    a_sel_frozen_run: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_r == CONVERT && !finish) |=> $stable(sel_r))
        else $error("selection moved during conversion");
    a_power_off_idle: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !ctrl_a_r[ENABLE_BIT] |-> (!o_power && o_sel == '0))
        else $error("analog path active while disabled");
    a_free_run_again: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (finish && ctrl_a_r[AUTO_BIT] && trig_sel_r == TRIG_SELF_DONE
        && enable) |=> (state_r == PENDING))
        else $error("free running did not restart");
    a_first_long: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_r == PENDING && tick && enable)
        |=> (cyc_r == (first_r_past ? FIRST_CYCLES : NORMAL_CYCLES)))
        else $error("wrong conversion length");
    // delayed copy of first_r for a_first_long
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            first_r_past <= 1'b1;
        end
        else
        begin
            first_r_past <= first_r;
        end
    end
endmodule // conv_ctrl
`default_nettype wire

// [conv_core_model.sv]
/*
 * behavioural model of the analog sampling core behind conv_ctrl.
 * assumes the bench hands over the code to convert before each start.
 */
`default_nettype none
module conv_core_model
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_power, // core powered
    input wire logic i_sample, // start of conversion pulse
    input wire logic [9:0] i_value, // analog level as a code
    output logic [9:0] o_code // code handed back at conversion end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_r; // code captured at the sample pulse
    // --------------------------------------------------------------
    // sample and hold
    // --------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            held_r <= 10'h000;
        else if (i_sample)
            held_r <= i_value;
    end
    // unpowered core drives the inverted held code, never the last code
    assign o_code = i_power ? held_r : ~held_r;
endmodule // conv_core_model
`default_nettype wire

// [sar_adc_conversion_control_tb.sv]
/*
 * self-checking bench for conv_ctrl with the analog core model.
 * assumes the register map and timing of conv_ctrl_pkg.
 */
`default_nettype none
module sar_adc_conversion_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_ctrl_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] trig = 8'h00;
    logic [9:0] code;
    logic [9:0] value = 10'h000;
    analog_sel_t sel;
    logic power, sample, done_ev;
    int n_fail = 0;
    int num_checks = 0;
    int n_done = 0; // completion events seen
    int n_samp = 0; // sample pulses seen
    int cyc_n = 0; // free cycle count
    int t_samp = 0; // cycle of the last sample pulse
    int t_done = 0; // cycle of the last completion event
    logic [9:0] c_a, c_b;
    logic [7:0] d;
    int base;
    // --------------------------------------------------------------
    // clock, design and core model
    // --------------------------------------------------------------
    always #5 i_clk = ~i_clk;
    conv_ctrl #(.TRIGGERS(8)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_triggers(trig), .i_code(code), .o_sel(sel),
        .o_power(power), .o_sample(sample), .o_done_event(done_ev));
    conv_core_model core (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_power(power), .i_sample(sample), .i_value(value),
        .o_code(code));
    always @(posedge i_clk)
    begin
        n_done <= n_done + int'(done_ev === 1'b1);
        n_samp <= n_samp + int'(sample === 1'b1);
        cyc_n <= cyc_n + 1;
        if (sample === 1'b1)
            t_samp <= cyc_n;
        if (done_ev === 1'b1)
            t_done <= cyc_n;
    end
    // --------------------------------------------------------------
    // checking and bus tasks
    // --------------------------------------------------------------
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wrb(logic [2:0] a, logic [7:0] v);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic rdb(logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 v = rdata; // data stand only in this cycle
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_done(int start);
        int k;
        k = 0;
        while (n_done == start && k < 400)
        begin
            @(posedge i_clk);
            #1 k++;
        end
        chk("completion", 16'(k < 400), 16'h1);
    endtask
    // expected result byte from code, alignment and byte half
    function automatic logic [7:0] res_byte(logic [9:0] c, logic left,
        logic high);
        logic [15:0] w;
        w = left ? {c, 6'h00} : {6'h00, c};
        return high ? w[15:8] : w[7:0];
    endfunction
    task automatic chk_res(logic [9:0] c, logic left);
        rdb(ADDR_RESULT_LOW, d);
        chk("result low", 16'(d), 16'(res_byte(c, left, 1'b0)));
        rdb(ADDR_RESULT_HIGH, d);
        chk("result high", 16'(d), 16'(res_byte(c, left, 1'b1)));
    endtask
    task automatic convert(logic [9:0] c);
        value <= c;
        base = n_done;
        wrb(ADDR_CONTROL_A, 8'hc0);
        idle(3);
        rdb(ADDR_CONTROL_A, d);
        chk("start busy", 16'(d[START_BIT]), 16'h1);
        wait_done(base);
    endtask
    // --------------------------------------------------------------
    // watchdog
    // --------------------------------------------------------------
    initial
    begin
        #500000;
        n_fail++;
        stop_test();
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h89b1));
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        // ascending: the low result read locks, the high one unlocks
        for (int i = 0; i < 6; i++)
        begin
            rdb(3'(i), d);
            chk("reset read", 16'(d), 16'(RESET_BYTE));
        end
        wrb(3'h5, 8'hff);
        rdb(3'h5, d);
        chk("unmapped", 16'(d), 16'h0);
        wrb(ADDR_CONTROL_A, 8'h40); // start without enable is refused
        wrb(ADDR_CHANNEL_SELECT, 8'h47);
        idle(60);
        chk("no launch", 16'(n_samp), 16'h0);
        chk("sel off", 16'(sel), 16'h0);
        chk("power off", 16'(power), 16'h0);
        // first conversion after enable, right aligned
        c_a = 10'($urandom());
        convert(c_a);
        chk("sel on", 16'(sel), 16'h27);
        chk("first len", 16'(t_done - t_samp), 16'(2 * FIRST_CYCLES));
        rdb(ADDR_CONTROL_A, d);
        chk("start clear", 16'(d[START_BIT]), 16'h0);
        chk("done flag", 16'(d[DONE_BIT]), 16'h1);
        chk_res(c_a, 1'b0);
        // random codes, left aligned, back to back
        wrb(ADDR_CHANNEL_SELECT, 8'h20);
        repeat (4)
        begin
            c_a = 10'($urandom());
            convert(c_a);
            chk("len", 16'(t_done - t_samp), 16'(2 * NORMAL_CYCLES));
            chk_res(c_a, 1'b1);
        end
        // lock: low read holds both bytes, done event still comes
        wrb(ADDR_CHANNEL_SELECT, 8'h00);
        c_a = 10'h3ff;
        convert(c_a);
        rdb(ADDR_RESULT_LOW, d);
        c_b = 10'h000;
        convert(c_b);
        rdb(ADDR_RESULT_HIGH, d);
        chk("locked high", 16'(d), 16'(res_byte(c_a, 1'b0, 1'b1)));
        chk_res(c_a, 1'b0);
        // slower converter clock: prescale select 3 divides by 8
        base = n_done;
        wrb(ADDR_CONTROL_A, 8'hc3);
        wait_done(base);
        chk("slow len", 16'(t_done - t_samp), 16'(8 * NORMAL_CYCLES));
        // channel change during a conversion waits for the end
        value <= 10'h155;
        base = n_done;
        wrb(ADDR_CONTROL_A, 8'hc0);
        wrb(ADDR_CHANNEL_SELECT, 8'h83);
        idle(4);
        chk("sel frozen", 16'(sel), 16'h00);
        wait_done(base);
        idle(2);
        chk("sel updated", 16'(sel), 16'h43);
        chk_res(10'h155, 1'b0);
        // auto trigger on source 3
        wrb(ADDR_CONTROL_B, 8'h03);
        wrb(ADDR_CONTROL_A, 8'ha0);
        base = n_samp;
        value <= 10'h2a5;
        trig[3] <= 1'b1;
        idle(10);
        chk("trig start", 16'(n_samp - base), 16'h1);
        rdb(ADDR_CONTROL_A, d);
        chk("auto busy", 16'(d[START_BIT]), 16'h1);
        trig[3] <= 1'b0;
        idle(2);
        trig[3] <= 1'b1; // edge during conversion
        idle(120);
        chk("no retrigger", 16'(n_samp - base), 16'h1);
        chk_res(10'h2a5, 1'b0);
        trig[3] <= 1'b0;
        idle(2);
        trig[3] <= 1'b1;
        idle(10);
        chk("next edge", 16'(n_samp - base), 16'h2);
        trig[3] <= 1'b0;
        idle(60);
        // free running: own done flag as trigger, flag left set
        wrb(ADDR_CONTROL_B, 8'(TRIG_SELF_DONE));
        idle(60);
        chk("needs start", 16'(n_samp - base), 16'h2);
        base = n_done;
        wrb(ADDR_CONTROL_A, 8'he0);
        idle(150);
        chk("free run", 16'(n_done - base > 3), 16'h1);
        // disable stops everything
        wrb(ADDR_CONTROL_A, 8'h00);
        idle(60);
        chk("off power", 16'(power), 16'h0);
        chk("off sel", 16'(sel), 16'h0);
        base = n_samp;
        idle(60);
        chk("off idle", 16'(n_samp - base), 16'h0);
        stop_test();
    end
endmodule // sar_adc_conversion_control_tb
`default_nettype wire
